// *** verilog/aio_scale.sv ***
// Analog input scaling, output source selection and periodic output update
`timescale 1ns/1ps
`default_nettype none
module aio_scale (
    input wire logic core_clk,                 // 25 MHz clock
    input wire logic rst,                      // Synchronous reset, high
    input wire aio_pkg::aio_bus_t bus,         // Register request
    output logic [15:0] rdata,                 // Read data, cycle after strobe
    input wire logic [9:0] ain_sample,         // Converter code, 0.1 % of 10 V
    input wire aio_pkg::aio_meas_t meas,       // Measured quantities
    output logic [9:0] ain_reading,            // Scaled input, 0.1 %
    output logic [9:0] aout_code,              // Output DAC code, 0.1 %
    output logic aout_strobe                   // Pulse on each refresh
);
    import aio_pkg::*;
    `include "aio_params.svh"

    // ==========================================
    // State
    typedef struct packed {
        logic [6:0] in_span;
        logic [6:0] in_ofs;
        aio_src_t src;
        logic [6:0] out_span;
        logic [6:0] out_ofs;
        logic [9:0] ain_s1;
        logic [9:0] ain_s2;
        logic [9:0] reading;
        logic [9:0] code;
        logic strobe;
        logic [19:0] tick;
        logic [15:0] rdata;
    } aio_state_t;

    aio_state_t st_r;
    aio_state_t st_nxt;

    // ==========================================
    // Input scaling
    logic [10:0] ofs_tenths;
    logic [10:0] span_tenths;
    logic [10:0] diff;
    logic [20:0] in_num;
    logic [20:0] in_q;
    logic [9:0] in_pct;

    always_comb begin
        ofs_tenths = 11'(st_r.in_ofs) * 11'h00A;
        span_tenths = 11'(st_r.in_span) * 11'h00A;
        if (11'(st_r.ain_s2) <= ofs_tenths) begin
            diff = 11'h000;
        end else begin
            diff = 11'(st_r.ain_s2) - ofs_tenths;
        end
        in_num = 21'(diff) * 21'(`AIO_FULL);
        in_q = in_num / 21'(span_tenths);
        if (in_q > 21'(`AIO_FULL)) begin
            in_pct = `AIO_FULL;
        end else begin
            in_pct = in_q[9:0];
        end
    end

    // ==========================================
    // Power source divider
    logic [31:0] pwr_fs;
    logic [9:0] pwr_pct;

    always_comb begin
        unique case (st_r.src)
            AIO_SRC_PWR10K: pwr_fs = 32'h0000_2710;
            AIO_SRC_PWR100K: pwr_fs = 32'h0001_86A0;
            AIO_SRC_PWR1M: pwr_fs = 32'h000F_4240;
            AIO_SRC_PWR10M: pwr_fs = 32'h0098_9680;
            default: pwr_fs = 32'h0000_2710;
        endcase
    end

    aio_div u_pwr_div (
        .num(42'(meas.power_w) * 42'h000_0000_03E8),
        .den(pwr_fs),
        .quo(pwr_pct)
    );

    // ==========================================
    // Source selection, 0.1 % of function full scale
    function automatic logic [9:0] pct_of(input logic [15:0] v, input logic [15:0] fs);
        logic [25:0] q;
        q = (26'(v) * 26'(`AIO_FULL)) / 26'(fs);
        return (q > 26'(`AIO_FULL)) ? `AIO_FULL : q[9:0];
    endfunction : pct_of

    logic [9:0] req;

    always_comb begin
        unique case (st_r.src)
            AIO_SRC_OFF: req = 10'h000;
            AIO_SRC_CUR200: req = pct_of(meas.cur_rms_pct, 16'h07D0);
            AIO_SRC_CUR800: req = pct_of(meas.cur_rms_pct, 16'h1F40);
            AIO_SRC_VOLT150: req = pct_of(meas.volt_rms_pct, 16'h05DC);
            AIO_SRC_OVL150: req = pct_of(meas.ovl_pct, 16'h05DC);
            AIO_SRC_PWR10K, AIO_SRC_PWR100K, AIO_SRC_PWR1M, AIO_SRC_PWR10M: req = pwr_pct;
            AIO_SRC_AIN: req = st_r.reading;
            AIO_SRC_FIRING: req = (st_r.src == AIO_SRC_FIRING && meas.firing_pct > `AIO_FULL) ?
                `AIO_FULL : meas.firing_pct;
            AIO_SRC_CAL: req = `AIO_FULL;
            default: req = 10'h000;
        endcase
    end

    // ==========================================
    // Output span, offset and limit
    logic [17:0] out_sum;
    logic [9:0] out_pct;

    always_comb begin
        out_sum = (18'(req) * 18'(st_r.out_span)) / 18'h00064
            + 18'(st_r.out_ofs) * 18'h0000A;
        if (st_r.src == AIO_SRC_OFF) begin
            out_pct = 10'h000;
        end else if (out_sum > 18'(`AIO_FULL)) begin
            out_pct = `AIO_FULL;
        end else begin
            out_pct = out_sum[9:0];
        end
    end

    // ==========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ain_s1 = ain_sample;
        st_nxt.ain_s2 = st_r.ain_s1;
        st_nxt.reading = in_pct;
        st_nxt.strobe = 1'b0;
        if (st_r.tick == 20'(`AIO_REFRESH_CYC - 1)) begin
            st_nxt.tick = 20'h00000;
            st_nxt.code = out_pct;
            st_nxt.strobe = 1'b1;
        end else begin
            st_nxt.tick = st_r.tick + 20'h00001;
        end
        if (bus.wr) begin
            unique case (bus.addr)
                `AIO_ADDR_IN_SPAN: begin
                    if (bus.wdata >= 16'h0001 && bus.wdata <= 16'(`AIO_IN_SPAN_MAX)) begin
                        st_nxt.in_span = bus.wdata[6:0];
                    end
                end
                `AIO_ADDR_IN_OFS: begin
                    if (bus.wdata <= 16'(`AIO_IN_OFS_MAX)) begin
                        st_nxt.in_ofs = bus.wdata[6:0];
                    end
                end
                `AIO_ADDR_OUT_SEL: begin
                    if (bus.wdata <= 16'(AIO_SRC_CAL)) begin
                        st_nxt.src = aio_src_t'(bus.wdata[3:0]);
                    end
                end
                `AIO_ADDR_OUT_SPAN: begin
                    if (bus.wdata >= 16'h0001 && bus.wdata <= 16'(`AIO_OUT_SPAN_MAX)) begin
                        st_nxt.out_span = bus.wdata[6:0];
                    end
                end
                `AIO_ADDR_OUT_OFS: begin
                    if (bus.wdata <= 16'(`AIO_OUT_OFS_MAX)) begin
                        st_nxt.out_ofs = bus.wdata[6:0];
                    end
                end
                default: begin
                end
            endcase
        end
        st_nxt.rdata = 16'h0000;
        if (bus.rd) begin
            unique case (bus.addr)
                `AIO_ADDR_IN_SPAN: st_nxt.rdata = 16'(st_r.in_span);
                `AIO_ADDR_IN_OFS: st_nxt.rdata = 16'(st_r.in_ofs);
                `AIO_ADDR_OUT_SEL: st_nxt.rdata = 16'(st_r.src);
                `AIO_ADDR_OUT_SPAN: st_nxt.rdata = 16'(st_r.out_span);
                `AIO_ADDR_OUT_OFS: st_nxt.rdata = 16'(st_r.out_ofs);
                `AIO_ADDR_IN_READ: st_nxt.rdata = 16'(st_r.reading);
                `AIO_ADDR_OUT_CODE: st_nxt.rdata = 16'(st_r.code);
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.in_span <= `AIO_IN_SPAN_RST;
            st_r.out_span <= `AIO_OUT_SPAN_RST;
            st_r.src <= AIO_SRC_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign ain_reading = st_r.reading;
    assign aout_code = st_r.code;
    assign aout_strobe = st_r.strobe;
endmodule : aio_scale
`default_nettype wire

// *** inc/aio_params.svh ***
// Constants for the analog input scaling and output selection block
// Operation
// - Input span accepted 1 to 100 percent, 100 after reset.
// - Input full scale reached at span times ten volts.
// - Offset and span apply together; 80/20 maps 4-20 mA to 0-100.
// - Input reading saturates at 100 percent.
// - Input offset 0 to 99 percent, default 0, subtracted first.
// - Input reading saturates at 0 percent.
// - Output source default is off, output disabled.
// - RMS current 0-200, current 0-800, voltage 0-150 sources.
// - Power sources 10 kW, 100 kW, 1 MW, 10 MW full scale.
// - Source reproducing the scaled analog input reading.
// - Source giving motor voltage from firing angle.
// - Calibration source always commands 100 percent.
// - Output recomputed and refreshed every 25 ms.
// - Output span accepted 1 to 125 percent, 100 after reset.
// - Output request multiplied by output span.
// - Output offset added; 50 percent gives half scale at 0 request.
// - Final output limited to 100 percent of full scale.
`ifndef AIO_PARAMS_SVH
`define AIO_PARAMS_SVH
// ==========================================
// Register offsets
`define AIO_ADDR_IN_SPAN 4'h0
`define AIO_ADDR_IN_OFS 4'h1
`define AIO_ADDR_OUT_SEL 4'h2
`define AIO_ADDR_OUT_SPAN 4'h3
`define AIO_ADDR_OUT_OFS 4'h4
`define AIO_ADDR_IN_READ 4'h5
`define AIO_ADDR_OUT_CODE 4'h6
// ==========================================
// Reset values and limits (percent)
`define AIO_IN_SPAN_RST 7'h64
`define AIO_IN_SPAN_MAX 7'h64
`define AIO_IN_OFS_MAX 7'h63
`define AIO_OUT_SPAN_RST 7'h64
`define AIO_OUT_SPAN_MAX 7'h7D
`define AIO_OUT_OFS_MAX 7'h63
// Full-scale percent in 0.1 % units
`define AIO_FULL 10'h3E8
// ==========================================
// Timing
`define AIO_CLK_HZ 25000000
`define AIO_REFRESH_US 25000
`define AIO_REFRESH_CYC ((`AIO_CLK_HZ / 1000000) * `AIO_REFRESH_US)
`endif

// *** inc/aio_pkg.sv ***
// Types for the analog input scaling and output selection block
package aio_pkg;
    typedef enum logic [3:0] {
        AIO_SRC_OFF, AIO_SRC_CUR200, AIO_SRC_CUR800, AIO_SRC_VOLT150,
        AIO_SRC_OVL150, AIO_SRC_PWR10K, AIO_SRC_PWR100K, AIO_SRC_PWR1M,
        AIO_SRC_PWR10M, AIO_SRC_AIN, AIO_SRC_FIRING, AIO_SRC_CAL
    } aio_src_t;

    // Measured quantities, all unsigned
    typedef struct packed {
        logic [15:0] cur_rms_pct;   // Motor current, percent of FLA x10
        logic [15:0] volt_rms_pct;  // Line voltage, percent x10
        logic [15:0] ovl_pct;       // Thermal overload, percent x10
        logic [31:0] power_w;       // Filtered real power, watts
        logic [9:0] firing_pct;     // Motor voltage from firing, 0.1 %
    } aio_meas_t;

    // Register-bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } aio_bus_t;
endpackage : aio_pkg

// *** verilog/aio_div.sv ***
// Divider turning a measured quantity into 0.1 % of its full scale
`timescale 1ns/1ps
`default_nettype none
module aio_div (
    input wire logic [41:0] num,   // Dividend, already times 1000
    input wire logic [31:0] den,   // Full-scale divisor, non-zero
    output logic [9:0] quo         // Quotient clamped to 1000
);
    import aio_pkg::*;
    `include "aio_params.svh"
    logic [41:0] q;
    always_comb begin
        q = num / {10'h000, den};
        quo = (q > 42'(`AIO_FULL)) ? `AIO_FULL : q[9:0];
    end
endmodule : aio_div
`default_nettype wire

// *** test/aio_scale_sva.sv ***
// Port checker for the analog scaling block
`timescale 1ns/1ps
`default_nettype none
module aio_scale_sva (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire aio_pkg::aio_bus_t bus, // Request
    input wire logic [15:0] rdata, // Read data
    input wire logic [9:0] ain_sample, // Sample
    input wire aio_pkg::aio_meas_t meas, // Measures
    input wire logic [9:0] ain_reading, // Reading
    input wire logic [9:0] aout_code, // Output code
    input wire logic aout_strobe // Refresh pulse
);
    import aio_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property (!bus.rd |=> rdata == 16'h0) else $error("rdata not idle");
    a_unmapped_rd: assert property (bus.rd && bus.addr > 4'h6 |=> rdata == 16'h0) else $error("unmapped read");
    a_span_back: assert property ((bus.wr && bus.addr == 4'h0 && bus.wdata inside {[1:100]}) ##1
        (bus.rd && bus.addr == 4'h0) |=> rdata == $past(bus.wdata, 2)) else $error("span readback");
    a_reading_max: assert property (ain_reading <= 10'h3E8) else $error("reading above full");
    a_zero_in: assert property ((ain_sample == 10'h0)[*4] |-> ain_reading == 10'h0) else $error("zero in");
    a_code_max: assert property (aout_code <= 10'h3E8) else $error("code above full");
    a_code_hold: assert property (!aout_strobe |-> $stable(aout_code)) else $error("code moved");
    a_strobe_one: assert property (aout_strobe |=> !aout_strobe) else $error("strobe too long");
    a_no_early: assert property ($fell(rst) |-> (!aout_strobe)[*8]) else $error("early refresh");
endmodule : aio_scale_sva
bind aio_scale aio_scale_sva aio_scale_sva_inst (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .ain_sample(ain_sample), .meas(meas), .ain_reading(ain_reading), .aout_code(aout_code),
    .aout_strobe(aout_strobe));
`default_nettype wire

// *** test/aio_far.sv ***
// Signal source and output receiver on the far side
`timescale 1ns/1ps
`default_nettype none
module aio_far (
    input wire logic core_clk, // Clock
    input wire logic [9:0] level, // Commanded input level
    output logic [9:0] ain_sample, // Converter code
    output aio_pkg::aio_meas_t meas, // Measured quantities
    input wire logic [9:0] aout_code, // Output code
    input wire logic aout_strobe, // Refresh pulse
    output logic [9:0] seen_code // Last code received
);
    import aio_pkg::*;
    assign meas = '{cur_rms_pct: 16'h3E8, volt_rms_pct: 16'h3E8, ovl_pct: 16'h1F4,
        power_w: 32'h1388, firing_pct: 10'h1F4};
    always @(posedge core_clk) begin
        ain_sample <= level;
        if (aout_strobe) begin
            seen_code <= aout_code;
        end
    end
endmodule : aio_far
`default_nettype wire

// *** test/test_analog_io_scaling.sv ***
// Testbench for the analog scaling block
`timescale 1ns/1ps
`default_nettype none
module test_analog_io_scaling;
    import aio_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    aio_bus_t bus = '0;
    logic [9:0] level = 10'h0;
    logic [15:0] rdata;
    logic [9:0] ain_sample, ain_reading, aout_code, seen_code;
    logic aout_strobe;
    aio_meas_t meas;
    int checked = 0;
    int miscompares = 0;
    always #20 core_clk = ~core_clk;
    aio_scale aio_scale_inst (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata), .ain_sample(ain_sample),
        .meas(meas), .ain_reading(ain_reading), .aout_code(aout_code), .aout_strobe(aout_strobe));
    aio_far aio_far_inst (.core_clk(core_clk), .level(level), .ain_sample(ain_sample), .meas(meas),
        .aout_code(aout_code), .aout_strobe(aout_strobe), .seen_code(seen_code));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic put(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : put
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        put(a, 16'h0, 1'b0, 1'b1);
        put(4'h0, 16'h0, 1'b0, 1'b0);
        @(negedge core_clk);
        check(rdata, exp);
    endtask : rd_chk
    task automatic reset_values;
        rd_chk(4'h0, 16'h64);
        rd_chk(4'h1, 16'h0);
        rd_chk(4'h2, 16'h0);
        rd_chk(4'h3, 16'h64);
        rd_chk(4'h6, 16'h0);
        rd_chk(4'hF, 16'h0);
    endtask : reset_values
    task automatic refusals;
        put(4'h0, 16'h0, 1'b1, 1'b0);
        rd_chk(4'h0, 16'h64);
        put(4'h0, 16'h65, 1'b1, 1'b0);
        put(4'h0, 16'h3C, 1'b1, 1'b0);
        rd_chk(4'h0, 16'h3C);
        put(4'h1, 16'h64, 1'b1, 1'b0);
        rd_chk(4'h1, 16'h0);
        put(4'h3, 16'h7E, 1'b1, 1'b0);
        rd_chk(4'h3, 16'h64);
        put(4'h3, 16'h7D, 1'b1, 1'b0);
        rd_chk(4'h3, 16'h7D);
        for (int i = 11; i >= 0; i--) begin
            put(4'h2, 16'(i), 1'b1, 1'b0);
            rd_chk(4'h2, 16'(i));
        end
        put(4'h2, 16'hC, 1'b1, 1'b0);
        rd_chk(4'h2, 16'h0);
    endtask : refusals
    task automatic scale_case(input int span, input int ofs, input int s);
        int d;
        int exp;
        d = s - 10 * ofs;
        exp = (d <= 0) ? 0 : d * 1000 / (10 * span);
        exp = (exp > 1000) ? 1000 : exp;
        put(4'h0, 16'(span), 1'b1, 1'b0);
        put(4'h1, 16'(ofs), 1'b1, 1'b0);
        put(4'h0, 16'h0, 1'b0, 1'b0);
        level <= 10'(s);
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        check({6'h0, ain_reading}, 16'(exp));
        rd_chk(4'h5, 16'(exp));
    endtask : scale_case
    // Output offset limits, then a reset in mid-run brings output source, output offset and input span back
    task automatic mid_reset;
        put(4'h4, 16'h32, 1'b1, 1'b0);
        rd_chk(4'h4, 16'h32);
        put(4'h4, 16'h64, 1'b1, 1'b0);
        rd_chk(4'h4, 16'h32);
        put(4'h2, 16'h9, 1'b1, 1'b0);
        level <= 10'h1F4;
        put(4'h0, 16'h0, 1'b0, 1'b0);
        repeat (5) @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check({6'h0, ain_reading}, 16'h0);
        check({6'h0, aout_code}, 16'h0);
        check({15'h0, aout_strobe}, 16'h0);
        check(rdata, 16'h0);
        rd_chk(4'h2, 16'h0);
        rd_chk(4'h4, 16'h0);
        rd_chk(4'h0, 16'h64);
        rd_chk(4'h5, 16'h1F4);
    endtask : mid_reset
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        reset_values();
        refusals();
        scale_case(100, 0, 1000);
        scale_case(50, 0, 250);
        scale_case(50, 0, 700);
        scale_case(80, 20, 200);
        scale_case(80, 20, 1000);
        scale_case(80, 20, 600);
        scale_case(100, 20, 200);
        scale_case(100, 20, 100);
        scale_case(100, 0, 0);
        mid_reset();
        check({6'h0, aout_code}, 16'h0);
        end_of_test();
    end
endmodule : test_analog_io_scaling
`default_nettype wire
